/* File: hdl/ccr_pkg.sv */
// Operation
// - Temp compensation code: off, 60, 40, 25 degrees
// - Supply compensation bit enables battery compensation
// - Blanking code picks one of eight times
// - Shunt mode: blanking only gates no-fault report
// - Re-engage by toggle, or readout then toggle
// - Sense select: drain-source zero, shunt one
// - Open-load current 100 uA or 1 mA
// - Gate current: external, 20, 5, 1 mA
// - High-side N or P transistor select bit
// - Side select: low-side zero, high-side one
// - Bit zero is odd parity over word
// - Readback bit picks fixed or actual threshold
// - Six-bit overcurrent threshold code, reset zero
// - All fields reset on power-on or pin
// - Bit 27 zero writes, one only reads
// - Reply bits 31..28 carry command number
package ccr_pkg;
  // ----------------------------------------
  // Frame field positions
  // ----------------------------------------
  localparam int CCR_CMD_MSB = 31;
  localparam int CCR_CMD_LSB = 28;
  localparam int CCR_RW_BIT = 27;
  localparam int CCR_UPPER_MSB = 26;
  localparam int CCR_UPPER_LSB = 22;
  localparam int CCR_READSEL_BIT = 21;
  localparam int CCR_THR_MSB = 20;
  localparam int CCR_THR_LSB = 15;
  localparam int CCR_TEMP_MSB = 14;
  localparam int CCR_TEMP_LSB = 13;
  localparam int CCR_SUPPLY_BIT = 12;
  localparam int CCR_BLANK_MSB = 11;
  localparam int CCR_BLANK_LSB = 9;
  localparam int CCR_REENG_BIT = 8;
  localparam int CCR_SENSE_BIT = 7;
  localparam int CCR_OPENLOAD_BIT = 6;
  localparam int CCR_GATE_MSB = 5;
  localparam int CCR_GATE_LSB = 4;
  localparam int CCR_NP_BIT = 3;
  localparam int CCR_SIDE_BIT = 2;
  localparam int CCR_ENABLE_BIT = 1;
  localparam int CCR_PARITY_BIT = 0;
  // ----------------------------------------
  // Command numbers and reset words
  // ----------------------------------------
  localparam logic [3:0] CCR_CMD_ONE = 4'h1;
  localparam logic [3:0] CCR_CMD_TWO = 4'h2;
  localparam logic [31:0] CCR_ONE_RESET = 32'h1EC00001;
  localparam logic [31:0] CCR_TWO_RESET = 32'h2EC00001;
  // ----------------------------------------
  // Blanking times in 0.1 us, indexed by code
  // ----------------------------------------
  localparam int CCR_CLK_MHZ = 50;
  localparam int CCR_BLANK_TENTHS_US [8] = '{111, 156, 200, 311, 422, 533, 978, 1422};
  // Cycles per blanking code, rounded up
  function automatic logic [13:0] ccr_blank_cycles(input logic [2:0] code);
    ccr_blank_cycles = 14'((CCR_BLANK_TENTHS_US[code] * CCR_CLK_MHZ + 9) / 10);
  endfunction
  // Temperature limits in degrees per code (0 = off)
  localparam int CCR_TEMP_LIMIT [4] = '{0, 60, 40, 25};
  // Gate current in mA per code (0 = external resistor)
  localparam int CCR_GATE_MA [4] = '{0, 20, 5, 1};
  // Open-load current in uA per bit
  localparam int CCR_OPENLOAD_UA [2] = '{100, 1000};
endpackage

/* File: hdl/ccr_channel.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Per-channel protection sequencer
// ----------------------------------------
module ccr_channel (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [31:0] cfg,
  input wire logic ctrl_in,
  input wire logic overcurrent_in,
  input wire logic diag_read,
  output logic drive_on,
  output logic blank_done,
  output logic oc_latched
);
  import ccr_pkg::*;

  typedef enum logic [1:0] {CCR_IDLE, CCR_ARMED, CCR_TRIPPED, CCR_READOUT} ccr_state_t;

  ccr_state_t state_reg, state_next;  // Protection state
  logic [13:0] blank_reg, blank_next;  // Blanking count
  logic ctrl_reg, ctrl_next;  // Previous control input
  logic drive_next, done_next, latch_next;
  logic toggle;  // Control switching event

  // Next-state logic
  always_comb
  begin
    toggle = ctrl_in ^ ctrl_reg;
    state_next = state_reg;
    blank_next = blank_reg;
    ctrl_next = ctrl_in;
    done_next = blank_done;
    latch_next = oc_latched;
    unique case (state_reg)
      CCR_IDLE:
      begin
        // Turn on starts the blanking window
        done_next = 1'b0;
        if (ctrl_in && cfg[CCR_ENABLE_BIT])
        begin
          state_next = CCR_ARMED;
          blank_next = ccr_blank_cycles(cfg[CCR_BLANK_MSB:CCR_BLANK_LSB]);
        end
      end
      CCR_ARMED:
      begin
        if (!ctrl_in || !cfg[CCR_ENABLE_BIT])
          state_next = CCR_IDLE;
        else if (blank_reg != 14'h0000)
        begin
          blank_next = blank_reg - 14'h0001;
          // Shunt sensing reacts at once; drain-source waits out blanking
          if (overcurrent_in && cfg[CCR_SENSE_BIT])
          begin
            state_next = CCR_TRIPPED;
            latch_next = 1'b1;
          end
        end
        else
        begin
          done_next = 1'b1;
          if (overcurrent_in)
          begin
            state_next = CCR_TRIPPED;
            latch_next = 1'b1;
            done_next = 1'b0;
          end
        end
      end
      CCR_TRIPPED:
      begin
        // Strict strategy needs a readout before the toggle counts
        if (cfg[CCR_REENG_BIT] && diag_read)
          state_next = CCR_READOUT;
        else if (!cfg[CCR_REENG_BIT] && toggle)
        begin
          state_next = CCR_IDLE;
          latch_next = 1'b0;
        end
      end
      CCR_READOUT:
      begin
        if (toggle)
        begin
          state_next = CCR_IDLE;
          latch_next = 1'b0;
        end
      end
    endcase
    drive_next = (state_next == CCR_ARMED);
  end

  // State registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= CCR_IDLE;
      blank_reg <= 14'h0000;
      ctrl_reg <= 1'b0;
      drive_on <= 1'b0;
      blank_done <= 1'b0;
      oc_latched <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      blank_reg <= blank_next;
      ctrl_reg <= ctrl_next;
      drive_on <= drive_next;
      blank_done <= done_next;
      oc_latched <= latch_next;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/ccr_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Channel one and two configuration words
// ----------------------------------------
module ccr_top #(
  parameter int CHANNELS = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic frame_valid,
  input wire logic [31:0] frame_in,
  input wire logic [1:0] ctrl_in,
  input wire logic [1:0] overcurrent_in,
  input wire logic [5:0] ch1_actual_threshold,
  input wire logic [5:0] ch2_actual_threshold,
  output logic reply_valid,
  output logic [31:0] reply_out,
  output logic [31:0] output_one_config,
  output logic [31:0] output_two_config,
  output logic [1:0] drive_on,
  output logic [1:0] blank_done,
  output logic [1:0] oc_latched,
  output logic [1:0] parity_error
);
  import ccr_pkg::*;

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (CHANNELS != 2)
  begin : g_bad
    $error("ccr_top serves exactly two channels");
  end

  logic [31:0] one_next, two_next, reply_next;
  logic valid_next;
  logic [1:0] perr_next;
  logic [3:0] cmd;  // Addressed command
  logic parity_ok;  // Odd parity across frame
  logic [1:0] diag_read;  // Readout pulse per channel
  logic [1:0] drive_w, done_w, latch_w;

  // ----------------------------------------
  // Frame decode and reply build
  // ----------------------------------------
  // Register next values
  always_comb
  begin
    cmd = frame_in[CCR_CMD_MSB:CCR_CMD_LSB];
    parity_ok = ^frame_in;
    one_next = output_one_config;
    two_next = output_two_config;
    reply_next = reply_out;
    valid_next = 1'b0;
    perr_next = 2'b00;
    diag_read = 2'b00;
    if (frame_valid)
    begin
      // Write only on write type with good parity
      if (!frame_in[CCR_RW_BIT] && parity_ok)
      begin
        if (cmd == CCR_CMD_ONE)
          one_next = {CCR_CMD_ONE, 1'b1, frame_in[CCR_UPPER_MSB:1], 1'b0};
        else if (cmd == CCR_CMD_TWO)
          two_next = {CCR_CMD_TWO, 1'b1, frame_in[CCR_UPPER_MSB:1], 1'b0};
      end
      if (!parity_ok)
        perr_next = {cmd == CCR_CMD_TWO, cmd == CCR_CMD_ONE};
      // Fix up stored parity
      one_next[CCR_PARITY_BIT] = ~(^one_next[31:1]);
      two_next[CCR_PARITY_BIT] = ~(^two_next[31:1]);
      if (cmd == CCR_CMD_ONE || cmd == CCR_CMD_TWO)
      begin
        valid_next = 1'b1;
        reply_next = (cmd == CCR_CMD_ONE) ? one_next : two_next;
        diag_read = {cmd == CCR_CMD_TWO, cmd == CCR_CMD_ONE};
        // Actual threshold shown when readback selected
        if (cmd == CCR_CMD_ONE && one_next[CCR_READSEL_BIT])
          reply_next[CCR_THR_MSB:CCR_THR_LSB] = ch1_actual_threshold;
        if (cmd == CCR_CMD_TWO && two_next[CCR_READSEL_BIT])
          reply_next[CCR_THR_MSB:CCR_THR_LSB] = ch2_actual_threshold;
        reply_next[CCR_PARITY_BIT] = ~(^reply_next[31:1]);
      end
    end
  end

  // Register stage
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      output_one_config <= CCR_ONE_RESET;
      output_two_config <= CCR_TWO_RESET;
      reply_out <= 32'h00000000;
      reply_valid <= 1'b0;
      parity_error <= 2'b00;
      drive_on <= 2'b00;
      blank_done <= 2'b00;
      oc_latched <= 2'b00;
    end
    else if (clk_en)
    begin
      output_one_config <= one_next;
      output_two_config <= two_next;
      reply_out <= reply_next;
      reply_valid <= valid_next;
      parity_error <= perr_next;
      drive_on <= drive_w;
      blank_done <= done_w;
      oc_latched <= latch_w;
    end
  end

  // ----------------------------------------
  // Channel sequencers
  // ----------------------------------------
  ccr_channel u_ch_one (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cfg(output_one_config),
    .ctrl_in(ctrl_in[0]),
    .overcurrent_in(overcurrent_in[0]),
    .diag_read(diag_read[0]),
    .drive_on(drive_w[0]),
    .blank_done(done_w[0]),
    .oc_latched(latch_w[0])
  );

  ccr_channel u_ch_two (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cfg(output_two_config),
    .ctrl_in(ctrl_in[1]),
    .overcurrent_in(overcurrent_in[1]),
    .diag_read(diag_read[1]),
    .drive_on(drive_w[1]),
    .blank_done(done_w[1]),
    .oc_latched(latch_w[1])
  );
endmodule
`default_nettype wire

/* File: bench/ccr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Host frame model
// ----------------------------------------
module ccr_host_model (
  input wire logic core_clk,
  input wire logic reply_valid,
  input wire logic [31:0] reply_out,
  output logic frame_valid,
  output logic [31:0] frame_in
);
  logic [31:0] got; // Last reply word
  logic seen; // Reply seen after frame
  // Idle bus at time zero
  initial
  begin
    frame_valid = 1'b0;
    frame_in = 32'h0;
  end
  // One frame; bad flips the parity bit
  task automatic send(input logic [3:0] c, input logic rw, input logic [26:0] b,
    input logic bad);
    logic [31:0] w;
    w = {c, rw, b[26:1], 1'b0};
    w[0] = ~^w[31:1] ^ bad;
    @(negedge core_clk);
    frame_valid = 1'b1;
    frame_in = w;
    @(negedge core_clk);
    frame_valid = 1'b0;
    frame_in = ~w; // Released bus shows no stale word
    seen = reply_valid;
    got = reply_out;
  endtask
endmodule
`default_nettype wire

/* File: bench/ccr_top_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Frame and word properties
// ----------------------------------------
module ccr_top_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic frame_valid,
  input wire logic [31:0] frame_in,
  input wire logic reply_valid,
  input wire logic [31:0] reply_out,
  input wire logic [31:0] output_one_config,
  input wire logic [31:0] output_two_config,
  input wire logic [1:0] parity_error
);
  wire logic take = frame_valid && clk_en; // Frame taken
  wire logic known = frame_in[31:28] == 4'h1 || frame_in[31:28] == 4'h2; // Our commands
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Good write to word one
  sequence s_wr_one;
    take && frame_in[31:27] == 5'h02 && ^frame_in;
  endsequence
  // Bad parity frame to word one
  sequence s_bad_one;
    take && frame_in[31:28] == 4'h1 && !(^frame_in);
  endsequence
  a_reply_follows: assert property (take && known |=> reply_valid)
    else $error("Reply missing");
  a_no_stray_reply: assert property (reply_valid |-> $past(take && known))
    else $error("Reply without frame");
  a_reply_command: assert property (reply_valid |-> reply_out[31:28] == $past(frame_in[31:28]))
    else $error("Reply command wrong");
  a_write_stores: assert property (s_wr_one |=> output_one_config[26:1] == $past(frame_in[26:1]))
    else $error("Write not stored");
  a_read_keeps: assert property (take && frame_in[27] |=> $stable(output_one_config))
    else $error("Read changed word");
  a_bad_parity: assert property (s_bad_one |=> parity_error[0] && $stable(output_one_config))
    else $error("Bad parity accepted");
  a_word_parity: assert property (output_two_config[0] == ~^output_two_config[31:1])
    else $error("Stored parity wrong");
  a_word_heads: assert property (output_one_config[31:27] == 5'h03 && output_two_config[31:27] == 5'h05)
    else $error("Word head wrong");
endmodule
bind ccr_top ccr_top_checker chk_u (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
  .frame_valid(frame_valid), .frame_in(frame_in), .reply_valid(reply_valid),
  .reply_out(reply_out), .output_one_config(output_one_config),
  .output_two_config(output_two_config), .parity_error(parity_error));
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Configuration word bench
// ----------------------------------------
module testbench;
  import ccr_pkg::*;
  logic core_clk, rst, frame_valid, reply_valid;
  logic [31:0] frame_in, reply_out, cfg1, cfg2;
  logic [1:0] ctrl_in, oc_in, drive_on, blank_done, oc_latched, parity_error;
  logic [5:0] thr1, thr2;
  logic [26:0] b; // Frame body
  int failures, comparisons;
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  ccr_top dut_u (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .frame_valid(frame_valid),
    .frame_in(frame_in), .ctrl_in(ctrl_in), .overcurrent_in(oc_in),
    .ch1_actual_threshold(thr1), .ch2_actual_threshold(thr2), .reply_valid(reply_valid),
    .reply_out(reply_out), .output_one_config(cfg1), .output_two_config(cfg2),
    .drive_on(drive_on), .blank_done(blank_done), .oc_latched(oc_latched),
    .parity_error(parity_error));
  ccr_host_model host_u (.core_clk(core_clk), .reply_valid(reply_valid),
    .reply_out(reply_out), .frame_valid(frame_valid), .frame_in(frame_in));
  // Compare and count
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected stored word
  function logic [31:0] word(input logic [3:0] c, input logic [26:0] v);
    word = {c, 1'b1, v[26:1], ~^{c, 1'b1, v[26:1]}};
  endfunction
  task end_of_test;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Bounded wait on channel two latch
  task wait_latch(input logic v);
    int n;
    n = 0;
    while (oc_latched[1] !== v && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
    check({31'h0, oc_latched[1]}, {31'h0, v});
    if (n == 60)
      end_of_test;
  endtask
  // Control switching event on channel two
  task toggle;
    @(negedge core_clk);
    ctrl_in[1] = 1'b0;
    repeat (3) @(negedge core_clk);
    ctrl_in[1] = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  // Every blanking, temp and gate code, eight threshold codes, readback bit zero, both words
  task t_fields;
    for (int i = 0; i < 8; i++)
    begin
      b = {5'(i), 1'b0, 6'(63 - i * 9), 2'(i), i[0], 3'(i), i[1], i[2], i[0], 2'(3 - i),
        i[1], i[2], ~i[0], 1'b0};
      host_u.send(4'h1, 1'b0, b, 1'b0);
      check(cfg1, word(4'h1, b));
      host_u.send(4'h2, 1'b0, b, 1'b0);
      check(host_u.got, word(4'h2, b));
    end
  endtask
  // Refused frames leave word one alone
  task t_refuse;
    host_u.send(4'h1, 1'b0, 27'h2AAA, 1'b1);
    check(cfg1, word(4'h1, b));
    host_u.send(4'h1, 1'b1, 27'h5555, 1'b0);
    check(host_u.got, word(4'h1, b));
    host_u.send(4'h3, 1'b0, 27'h0, 1'b0);
    check({31'h0, host_u.seen}, 32'h0);
  endtask
  // Actual threshold in the reply, fixed one in the stored word
  task t_readback;
    thr1 = 6'h2A;
    host_u.send(4'h1, 1'b0, 27'h0228000, 1'b0);
    check({26'h0, host_u.got[20:15]}, 32'h2A);
    check({26'h0, cfg1[20:15]}, 32'h05);
  endtask
  // Drain-source blanking, no-fault report and trip on channel one
  task t_blank;
    int n;
    n = 100;
    host_u.send(4'h1, 1'b0, 27'h2, 1'b0);
    ctrl_in[0] = 1'b1;
    oc_in[0] = 1'b1;
    repeat (100) @(negedge core_clk);
    check({31'h0, oc_latched[0]}, 32'h0);
    check({31'h0, drive_on[0]}, 32'h1);
    oc_in[0] = 1'b0;
    while (blank_done[0] !== 1'b1 && n < 700)
    begin
      @(negedge core_clk);
      n++;
    end
    // 11.1 us at 50 MHz is 555 cycles, plus three register stages
    check(n, 32'd558);
    if (n == 700)
      end_of_test;
    oc_in[0] = 1'b1;
    repeat (3) @(negedge core_clk);
    check({31'h0, oc_latched[0]}, 32'h1);
    check({31'h0, blank_done[0]}, 32'h0);
    check({31'h0, drive_on[0]}, 32'h0);
    ctrl_in[0] = 1'b0;
    oc_in[0] = 1'b0;
    repeat (3) @(negedge core_clk);
    check({31'h0, oc_latched[0]}, 32'h0);
  endtask
  // Shutdown and re-engage, both strategies
  task t_reengage;
    for (int r = 0; r < 2; r++)
    begin
      host_u.send(4'h2, 1'b0, 27'h82 | 27'(r << 8), 1'b0);
      ctrl_in[1] = 1'b1;
      oc_in[1] = 1'b1;
      repeat (2) @(negedge core_clk);
      oc_in[1] = 1'b0;
      wait_latch(1'b1);
      toggle;
      if (r == 1)
      begin
        check({31'h0, oc_latched[1]}, 32'h1);
        host_u.send(4'h2, 1'b1, 27'h0, 1'b0);
        toggle;
      end
      wait_latch(1'b0);
    end
  endtask
  // Reset in mid-run restores both words
  task t_reset;
    @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    check(cfg1, CCR_ONE_RESET);
    check(cfg2, CCR_TWO_RESET);
    rst = 1'b0;
    host_u.send(4'h2, 1'b1, 27'h0, 1'b0);
    check(host_u.got, CCR_TWO_RESET);
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    ctrl_in = 2'h0;
    oc_in = 2'h0;
    thr1 = 6'h0;
    thr2 = 6'h0C;
    failures = 0;
    comparisons = 0;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    check(cfg1, CCR_ONE_RESET);
    t_fields;
    t_refuse;
    t_readback;
    t_blank;
    t_reengage;
    t_reset;
    end_of_test;
  end
endmodule
`default_nettype wire
